// ===== rtl/stack_pull_rotate_exec.sv
// Execution datapath for stack pulls, returns and rotates
`timescale 1ns/1ps
`include "stack_exec_regs.svh"

module stack_pull_rotate_exec (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic [7:0]  opcode,
   input  wire logic [7:0]  operand_addr,
   input  wire logic [7:0]  acc_in,
   input  wire logic [7:0]  flag_in,
   input  wire logic [7:0]  sp_in,
   input  wire logic [15:0] pc_in,
   input  wire logic [7:0]  mem_rdata,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic [7:0]       mem_addr,
   output logic [7:0]       mem_wdata,
   output logic [7:0]       acc_out,
   output logic [7:0]       flag_register,
   output logic [7:0]       sp_out,
   output logic [15:0]      pc_out,
   output logic             busy,
   output logic             done
);
   typedef struct packed {
      stack_exec_pkg::exec_state_t st;
      logic [7:0]  op;
      logic [7:0]  addr;
      logic [7:0]  acc;
      logic [7:0]  flags;
      logic [7:0]  sp;
      logic [7:0]  return_addr_low;
      logic [7:0]  return_addr_high;
      logic [15:0] pc;
      logic        busy;
      logic        done;
      logic        rd;
      logic        rd_dly;
      logic        wr;
      logic [7:0]  bus_addr;
      logic [7:0]  wdata;
   } exec_q_t;

   exec_q_t    s_q;
   exec_q_t    s_d;
   mem_port_if bus ();

   // The port stage adds a cycle and the memory another, so a pull takes
   // its byte only once both rd and its delayed copy have dropped.
   logic        carry;
   logic        carry_in;
   logic [7:0]  sp_inc;
   logic        mem_op;

   always_comb begin
      s_d      = s_q;
      s_d.rd   = 1'b0;
      s_d.wr   = 1'b0;
      s_d.done = 1'b0;
      s_d.rd_dly = s_q.rd;
      carry    = s_q.flags[`FLAG_CARRY_BIT];
      carry_in = flag_in[`FLAG_CARRY_BIT];
      sp_inc   = 8'(s_q.sp + 8'h01);
      mem_op   = (s_q.op == `OP_ROL_MEM) || (s_q.op == `OP_ROR_MEM)
                 || (s_q.op == `OP_NIB_ROT);
      unique case (s_q.st)
         stack_exec_pkg::ST_IDLE: begin
            if (start) begin
               s_d.op    = opcode;
               s_d.addr  = operand_addr;
               s_d.acc   = acc_in;
               s_d.flags = flag_in;
               s_d.sp    = sp_in;
               s_d.pc    = pc_in;
               s_d.busy  = 1'b1;
               unique case (opcode)
                  `OP_PULL_ACC, `OP_PULL_FLAGS, `OP_RET_INT,
                  `OP_RET_SUB: begin
                     s_d.sp       = 8'(sp_in + 8'h01);
                     s_d.bus_addr = 8'(sp_in + 8'h01);
                     s_d.rd       = 1'b1;
                     s_d.st       = stack_exec_pkg::ST_PULL1;
                  end
                  `OP_ROL_MEM, `OP_ROR_MEM, `OP_NIB_ROT: begin
                     s_d.bus_addr = operand_addr;
                     s_d.rd       = 1'b1;
                     s_d.st       = stack_exec_pkg::ST_PULL1;
                  end
                  `OP_ROL_ACC: begin
                     s_d.acc = {acc_in[6:0], carry_in};
                     s_d.flags[`FLAG_CARRY_BIT] = acc_in[`MSB_BIT];
                     s_d.st  = stack_exec_pkg::ST_DONE;
                  end
                  `OP_ROR_ACC: begin
                     s_d.acc = {carry_in, acc_in[7:1]};
                     s_d.flags[`FLAG_CARRY_BIT] = acc_in[0];
                     s_d.st  = stack_exec_pkg::ST_DONE;
                  end
                  default: begin
                     s_d.st = stack_exec_pkg::ST_DONE;
                  end
               endcase
            end
         end
         stack_exec_pkg::ST_PULL1: begin
            // Data stands two cycles after rd, when rd_dly has dropped too
            if (!s_q.rd && !s_q.rd_dly) begin
               if (mem_op) begin
                  s_d.wr       = 1'b1;
                  s_d.bus_addr = s_q.addr;
                  if (s_q.op == `OP_ROL_MEM) begin
                     s_d.wdata = {mem_rdata[6:0], carry};
                     s_d.flags[`FLAG_CARRY_BIT] = mem_rdata[`MSB_BIT];
                  end else if (s_q.op == `OP_ROR_MEM) begin
                     s_d.wdata = {carry, mem_rdata[7:1]};
                     s_d.flags[`FLAG_CARRY_BIT] = mem_rdata[0];
                  end else begin
                     s_d.wdata = {mem_rdata[3:0], mem_rdata[7:4]};
                  end
                  s_d.st = stack_exec_pkg::ST_MWR;
               end else if (s_q.op == `OP_PULL_ACC) begin
                  s_d.acc = mem_rdata;
                  s_d.st  = stack_exec_pkg::ST_DONE;
               end else if (s_q.op == `OP_PULL_FLAGS) begin
                  s_d.flags = mem_rdata;
                  s_d.st    = stack_exec_pkg::ST_DONE;
               end else begin
                  if (s_q.op == `OP_RET_INT) begin
                     s_d.flags = mem_rdata;
                  end else begin
                     s_d.return_addr_low = mem_rdata;
                  end
                  s_d.sp       = sp_inc;
                  s_d.bus_addr = sp_inc;
                  s_d.rd       = 1'b1;
                  s_d.st       = stack_exec_pkg::ST_PULL2;
               end
            end
         end
         stack_exec_pkg::ST_PULL2: begin
            if (!s_q.rd && !s_q.rd_dly) begin
               if (s_q.op == `OP_RET_INT) begin
                  s_d.return_addr_low = mem_rdata;
                  s_d.sp       = sp_inc;
                  s_d.bus_addr = sp_inc;
                  s_d.rd       = 1'b1;
                  s_d.st       = stack_exec_pkg::ST_PULL3;
               end else begin
                  s_d.return_addr_high = mem_rdata;
                  s_d.pc = 16'({mem_rdata, s_q.return_addr_low}
                               + `PC_STEP);
                  s_d.st = stack_exec_pkg::ST_DONE;
               end
            end
         end
         stack_exec_pkg::ST_PULL3: begin
            if (!s_q.rd && !s_q.rd_dly) begin
               s_d.return_addr_high = mem_rdata;
               s_d.pc = {mem_rdata, s_q.return_addr_low};
               s_d.st = stack_exec_pkg::ST_DONE;
            end
         end
         stack_exec_pkg::ST_MWR: begin
            s_d.st = stack_exec_pkg::ST_DONE;
         end
         stack_exec_pkg::ST_DONE: begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st   = stack_exec_pkg::ST_IDLE;
         end
         default: begin
            s_d.st   = stack_exec_pkg::ST_IDLE;
            s_d.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q                  <= '0;
         s_q.st               <= stack_exec_pkg::ST_IDLE;
         s_q.sp               <= `SP_RESET;
         s_q.acc              <= `BYTE_RESET;
         s_q.flags            <= `BYTE_RESET;
         s_q.pc               <= `PC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.rd_req = s_q.rd;
   assign bus.wr_req = s_q.wr;
   assign bus.addr   = s_q.bus_addr;
   assign bus.wdata  = s_q.wdata;

   mem_port_stage i_mem_port_stage (
      .clock     (clock),
      .resetn    (resetn),
      .req       (bus.port),
      .mem_rd    (mem_rd),
      .mem_wr    (mem_wr),
      .mem_addr  (mem_addr),
      .mem_wdata (mem_wdata)
   );

   assign acc_out       = s_q.acc;
   assign flag_register = s_q.flags;
   assign sp_out        = s_q.sp;
   assign pc_out        = s_q.pc;
   assign busy          = s_q.busy;
   assign done          = s_q.done;
endmodule : stack_pull_rotate_exec

// ===== rtl/stack_exec_regs.svh
// Constants for the stack pull and rotate execution datapath
`ifndef STACK_EXEC_REGS_SVH
`define STACK_EXEC_REGS_SVH

`define OP_PULL_ACC      8'h68
`define OP_PULL_FLAGS    8'h28
`define OP_RET_INT       8'h40
`define OP_RET_SUB       8'h60
`define OP_ROL_ACC       8'h2A
`define OP_ROL_MEM       8'h26
`define OP_ROR_ACC       8'h6A
`define OP_ROR_MEM       8'h66
`define OP_NIB_ROT       8'h82
`define FLAG_CARRY_BIT   0
`define MSB_BIT          7
`define NIBBLE_SHIFT     4
`define SP_RESET         8'hFF
`define BYTE_RESET       8'h00
`define PC_RESET         16'h0000
`define PC_STEP          16'h0001

`endif

// ===== rtl/stack_exec_pkg.sv
// Types for the stack pull and rotate execution datapath
package stack_exec_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PULL1 = 3'b001,
      ST_PULL2 = 3'b011,
      ST_PULL3 = 3'b010,
      ST_MWR   = 3'b110,
      ST_DONE  = 3'b111
   } exec_state_t;
endpackage : stack_exec_pkg

// ===== rtl/mem_port_if.sv
// Memory bus signals between the sequencer and the bus port stage
`timescale 1ns/1ps
interface mem_port_if;
   logic       rd_req;
   logic       wr_req;
   logic [7:0] addr;
   logic [7:0] wdata;
   modport seq  (output rd_req, output wr_req, output addr, output wdata);
   modport port (input rd_req, input wr_req, input addr, input wdata);
endinterface : mem_port_if

// ===== rtl/mem_port_stage.sv
// Registered bus port stage driving the memory pins
`timescale 1ns/1ps
module mem_port_stage (
   input  wire logic clock,
   input  wire logic resetn,
   mem_port_if.port  req,
   output logic      mem_rd,
   output logic      mem_wr,
   output logic [7:0] mem_addr,
   output logic [7:0] mem_wdata
);
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } port_state_t;

   port_state_t s_q;
   port_state_t s_d;

   always_comb begin
      s_d.rd    = req.rd_req;
      s_d.wr    = req.wr_req;
      s_d.addr  = req.addr;
      s_d.wdata = req.wdata;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign mem_rd    = s_q.rd;
   assign mem_wr    = s_q.wr;
   assign mem_addr  = s_q.addr;
   assign mem_wdata = s_q.wdata;
endmodule : mem_port_stage

// ===== test/exec_chk.sv
// Assertion checker for the stack pull and rotate datapath
`timescale 1ns/1ps
module exec_chk (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        start,
   input wire logic [7:0]  opcode,
   input wire logic [7:0]  operand_addr,
   input wire logic [7:0]  acc_in,
   input wire logic [7:0]  flag_in,
   input wire logic [7:0]  sp_in,
   input wire logic [15:0] pc_in,
   input wire logic [7:0]  mem_rdata,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic [7:0]  mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic [7:0]  acc_out,
   input wire logic [7:0]  flag_register,
   input wire logic [7:0]  sp_out,
   input wire logic [15:0] pc_out,
   input wire logic        busy,
   input wire logic        done
);
   logic [7:0]  s_q, a_q, f_q, o_q, x_q, n_q, d_q;
   logic        v_q;
   logic [23:0] r_q;
   // Read bytes kept in arrival order, newest in the low byte
   always_ff @(posedge clock) begin
      v_q <= mem_rd;
      if (v_q) begin
         d_q <= mem_rdata;
         r_q <= {r_q[15:0], mem_rdata};
      end
      if (start && !busy) begin
         {s_q, a_q, f_q, o_q, x_q} <= {sp_in, acc_in, flag_in, opcode,
                                       operand_addr};
         n_q <= 8'h00;
      end else if (mem_rd) begin
         n_q <= n_q + 8'h01;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_go(op);
      start && !busy && opcode == op;
   endsequence
   AST_ACC_LOAD: assert property (s_go(8'h68) |-> ##4 acc_out == d_q)
      else $error("accumulator pull loaded wrong byte");
   AST_FLAG_LOAD: assert property (s_go(8'h28) |-> ##4
      flag_register == d_q)
      else $error("flag pull loaded wrong byte");
   AST_ROL: assert property (s_go(8'h2A) |-> ##2 done &&
      acc_out == {a_q[6:0], f_q[0]} && flag_register[0] == a_q[7])
      else $error("rotate left result wrong");
   AST_ROR: assert property (s_go(8'h6A) |-> ##2 done &&
      acc_out == {f_q[0], a_q[7:1]} && flag_register[0] == a_q[0])
      else $error("rotate right result wrong");
   AST_NIB: assert property (mem_wr && o_q == 8'h82 |->
      mem_addr == x_q && mem_wdata == {d_q[3:0], d_q[7:4]})
      else $error("nibble rotate write wrong");
   AST_ASC: assert property (mem_rd &&
      o_q inside {8'h68, 8'h28, 8'h40, 8'h60} |->
      mem_addr == s_q + n_q + 8'h01)
      else $error("stack read address wrong");
   // Port flop and memory put three cycles between successive stack pulls
   AST_RTI: assert property (s_go(8'h40) |-> ##11 done &&
      pc_out == {r_q[7:0], r_q[15:8]} && flag_register == r_q[23:16]
      && sp_out == s_q + 8'h03)
      else $error("interrupt return result wrong");
   AST_RTS: assert property (s_go(8'h60) |-> ##8 done &&
      pc_out == {r_q[7:0], r_q[15:8]} + 16'h0001 && sp_out == s_q + 8'h02)
      else $error("subroutine return result wrong");
   AST_BUSY: assert property (start && !busy |=> busy)
      else $error("busy not raised after an accepted start");
endmodule : exec_chk

bind stack_pull_rotate_exec exec_chk i_exec_chk (.clock, .resetn, .start,
   .opcode, .operand_addr, .acc_in, .flag_in, .sp_in, .pc_in, .mem_rdata,
   .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .acc_out, .flag_register,
   .sp_out, .pc_out, .busy, .done);

// ===== test/mem_model.sv
// Data and stack memory answering the datapath's bus strobes
`timescale 1ns/1ps
module mem_model (
   input wire logic       clock,
   input wire logic       mem_rd,
   input wire logic       mem_wr,
   input wire logic [7:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0]     mem_rdata
);
   logic [7:0] mem [256];
   // Outside a read the bus flips each cycle, so stale data sampled one cycle late cannot pass
   always @(posedge clock) begin
      if (mem_wr) mem[mem_addr] <= mem_wdata;
      mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
   end
endmodule : mem_model

// ===== test/tb_top.sv
// Testbench for the stack pull and rotate datapath
`timescale 1ns/1ps
`include "stack_exec_regs.svh"
module tb_top;
   logic        clock = 1'b0, resetn = 1'b0, start = 1'b0;
   logic [7:0]  opcode = 8'h00, operand_addr = 8'h00, acc_in = 8'h00;
   logic [7:0]  flag_in = 8'h00, sp_in = 8'h00;
   logic [15:0] pc_in = 16'h0000, pc_out;
   logic [7:0]  mem_rdata, mem_addr, mem_wdata, acc_out, flag_register;
   logic [7:0]  sp_out;
   logic        mem_rd, mem_wr, busy, done;
   int          n_fail = 0, n_tests = 0;
   stack_pull_rotate_exec i_stack_pull_rotate_exec (.clock, .resetn,
      .start, .opcode, .operand_addr, .acc_in, .flag_in, .sp_in, .pc_in,
      .mem_rdata, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .acc_out,
      .flag_register, .sp_out, .pc_out, .busy, .done);
   mem_model i_mem_model (.clock, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
      .mem_rdata);
   initial begin
      forever #5 clock = ~clock;
   end
   task report_and_stop;
      $display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task go(input logic [7:0] op, ad, a, f, s);
      int k;
      @(negedge clock);
      {opcode, operand_addr, acc_in, flag_in, sp_in} = {op, ad, a, f, s};
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20) begin
         @(negedge clock);
         k++;
      end
      chk("done", 16'h0001, 16'(done));
      // One more cycle; a rotate's memory write already lands on the edge that raises done
      @(negedge clock);
   endtask : go
   task t_pull;
      i_mem_model.mem[8'h41] = 8'hA5;
      i_mem_model.mem[8'h42] = 8'h3C;
      go(`OP_PULL_ACC, 8'h00, 8'h00, 8'h00, 8'h40);
      chk("acc", 16'h00A5, 16'(acc_out));
      chk("sp", 16'h0041, 16'(sp_out));
      go(`OP_PULL_FLAGS, 8'h00, 8'h00, 8'h00, 8'h41);
      chk("flags", 16'h003C, 16'(flag_register));
   endtask : t_pull
   task t_rot;
      i_mem_model.mem[8'h10] = 8'h80;
      i_mem_model.mem[8'h11] = 8'h01;
      go(`OP_ROL_ACC, 8'h00, 8'h81, 8'h00, 8'h00);
      chk("acc", 16'h0002, 16'(acc_out));
      chk("carry", 16'h0001, 16'(flag_register[0]));
      go(`OP_ROR_ACC, 8'h00, 8'h81, 8'h01, 8'h00);
      chk("acc", 16'h00C0, 16'(acc_out));
      chk("carry", 16'h0001, 16'(flag_register[0]));
      go(`OP_ROL_MEM, 8'h10, 8'h00, 8'h01, 8'h00);
      chk("mem", 16'h0001, 16'(i_mem_model.mem[8'h10]));
      chk("carry", 16'h0001, 16'(flag_register[0]));
      go(`OP_ROR_MEM, 8'h11, 8'h00, 8'h00, 8'h00);
      chk("mem", 16'h0000, 16'(i_mem_model.mem[8'h11]));
      chk("carry", 16'h0001, 16'(flag_register[0]));
   endtask : t_rot
   task t_nib;
      i_mem_model.mem[8'h20] = 8'hA5;
      pc_in = 16'h5AA5;
      go(`OP_NIB_ROT, 8'h20, 8'h00, 8'h01, 8'h00);
      chk("mem", 16'h005A, 16'(i_mem_model.mem[8'h20]));
      chk("carry", 16'h0001, 16'(flag_register[0]));
      chk("pc", 16'h5AA5, pc_out);
      // An opcode outside this group passes the CPU state through
      go(8'hEA, 8'h00, 8'h77, 8'h01, 8'h33);
      chk("acc", 16'h0077, 16'(acc_out));
      chk("sp", 16'h0033, 16'(sp_out));
      chk("pc", 16'h5AA5, pc_out);
   endtask : t_nib
   task t_ret;
      i_mem_model.mem[8'hFF] = 8'hC3;
      i_mem_model.mem[8'h00] = 8'h34;
      i_mem_model.mem[8'h01] = 8'h12;
      go(`OP_RET_INT, 8'h00, 8'h00, 8'h00, 8'hFE);
      chk("flags", 16'h00C3, 16'(flag_register));
      chk("pc", 16'h1234, pc_out);
      chk("sp", 16'h0001, 16'(sp_out));
      i_mem_model.mem[8'h00] = 8'hFF;
      go(`OP_RET_SUB, 8'h00, 8'h00, 8'h00, 8'hFF);
      chk("pc", 16'h1300, pc_out);
      chk("sp", 16'h0001, 16'(sp_out));
   endtask : t_ret
   initial begin
      repeat (10) @(negedge clock);
      chk("sp_rst", 16'h00FF, 16'(sp_out));
      resetn = 1'b1;
      t_pull;
      t_rot;
      t_nib;
      t_ret;
      report_and_stop;
   end
   initial begin
      #20000;
      n_fail++;
      report_and_stop;
   end
endmodule : tb_top
